// [logic/atcb_top.sv]
`include "atcb_defines.svh"
// Function
// (R1) timer clock is I/O clock when async select is 0, oscillator pin otherwise
// (R2) software rewrites counter, compare, control after async select changes
// (R3) async counter write sets counter busy; cleared when counter loaded
// (R4) async compare write sets compare busy; cleared when compare loaded
// (R5) async control write sets control busy; cleared when control loaded
// (R6) software never writes a buffered register while its busy flag is set
// (R7) counter read gives timer value; compare/control reads give temporary register
// (R8) writes go to a temporary register, loaded after two oscillator rising edges
// (R9) each buffered register owns its temporary register
// (R10) compare match suppressed while counter or compare transfer pending
// (R11) after timer wake-up, one oscillator cycle passes before new interrupt
// (R12) async oscillator runs in all sleep modes except power-down and standby
// (R13) wake-up in power-save/extended standby starts on next timer clock
// (R14) counter reads via register refreshed on each oscillator rising edge
// (R15) async flag sync takes three processor cycles plus one timer cycle
// (R16) compare output pin changes on timer clock, unsynchronized
// (R17) compare irq needs enable, global enable and compare flag all set
// (R18) overflow irq needs enable, global enable and overflow flag all set
// (R19) compare flag set on match; cleared by vector or writing one
// (R20) overflow flag set on overflow or PWM reversal at zero; vector or one clears
// (R21) software follows the ordered clock source switch procedure
// (R22) software waits for busy clear before sleeping with timer wake-up
module atcb_top #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // timer oscillator and power
    input wire logic timer_osc_in,
    input wire logic [2:0] sleep_mode,
    output logic osc_enable,
    output logic wake_req,
    // cpu interrupt side
    input wire logic vec_ack_compare,
    input wire logic vec_ack_overflow,
    output logic irq_compare,
    output logic irq_overflow,
    // compare output pin
    output logic compare_out
);

    atcb_pkg::atcb_state_s s;
    atcb_pkg::atcb_state_s n;

    logic osc_edge;
    logic tick;
    logic adv;
    logic suppress;
    logic cm_ev;
    logic ov_ev;
    logic evq_c;
    logic evq_o;
    logic set_c;
    logic set_o;
    logic clr_c;
    logic clr_o;
    logic wr_go;
    logic wr_en;
    logic force_cmp;
    logic saving;
    logic [7:0] rd;
    logic [1:0] com;
    logic [2:0] xfer;
    logic [2:0] sync_ld;
    logic [2:0][7:0] src;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `ATCB_OFF_STATUS) || (a == `ATCB_OFF_MASK) ||
                    (a == `ATCB_OFF_FLAGS) || (a == `ATCB_OFF_CNT) ||
                    (a == `ATCB_OFF_CMP) || (a == `ATCB_OFF_CTL) ||
                    (a == `ATCB_OFF_CPU);
    endfunction : is_mapped

    always_comb begin
        n = s;
        rd = 8'h00;
        xfer = 3'h0;
        sync_ld = 3'h0;
        force_cmp = 1'b0;
        cm_ev = 1'b0;
        ov_ev = 1'b0;
        osc_edge = timer_osc_in & ~s.osc_prev;
        n.osc_prev = timer_osc_in;
        saving = (sleep_mode == `ATCB_SLP_PSAVE) || (sleep_mode == `ATCB_SLP_EXTSTBY);
        n.osc_run = s.async & (sleep_mode != `ATCB_SLP_PDOWN) &
                    (sleep_mode != `ATCB_SLP_STANDBY); // [R12]
        // pin edges only count while the oscillator is allowed to run
        tick = s.async ? (osc_edge & s.osc_run) : 1'b1; // [R1]

        // write channel: address and data taken in either order
        if (s.awready && awvalid) begin
            n.aw_got = 1'b1;
            n.aw_addr = awaddr[7:0];
        end
        if (s.wready && wvalid) begin
            n.w_got = 1'b1;
            n.w_data = wdata[7:0];
            n.w_lane = wstrb[0];
        end
        wr_go = s.aw_got & s.w_got & ~s.bvalid;
        wr_en = wr_go & s.w_lane & is_mapped(s.aw_addr);
        if (wr_go) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = is_mapped(s.aw_addr) ? `ATCB_RESP_OKAY : `ATCB_RESP_SLVERR;
        end
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
        end

        // two-edge transfer engine, one per buffered register
        for (int i = 0; i < 3; i++) begin
            if (s.pend[i] && tick) begin
                if (s.ecnt[i] == `ATCB_XFER_LAST) begin
                    xfer[i] = 1'b1; // [R8] [R3] [R4] [R5]
                    n.pend[i] = 1'b0;
                    n.ecnt[i] = 2'h0;
                end else begin
                    n.ecnt[i] = s.ecnt[i] + 2'h1;
                end
            end
        end

        // register writes
        if (wr_en) begin
            unique case (s.aw_addr)
                `ATCB_OFF_STATUS: n.async = s.w_data[`ATCB_ST_ASYNC]; // [R1]
                `ATCB_OFF_MASK: begin
                    n.ien[`ATCB_BIT_CMP] = s.w_data[`ATCB_BIT_CMP];
                    n.ien[`ATCB_BIT_OVF] = s.w_data[`ATCB_BIT_OVF];
                end
                `ATCB_OFF_CPU: n.gie = s.w_data[`ATCB_CPU_GIE];
                `ATCB_OFF_CNT, `ATCB_OFF_CMP, `ATCB_OFF_CTL: begin
                    for (int i = 0; i < 3; i++) begin
                        if ((i == `ATCB_IX_CNT && s.aw_addr == `ATCB_OFF_CNT) ||
                            (i == `ATCB_IX_CMP && s.aw_addr == `ATCB_OFF_CMP) ||
                            (i == `ATCB_IX_CTL && s.aw_addr == `ATCB_OFF_CTL)) begin
                            n.tmp[i] = s.w_data; // [R9]
                            if (s.async) begin
                                // a rewrite restarts the two-edge count
                                n.pend[i] = 1'b1; // [R3] [R4] [R5]
                                n.ecnt[i] = 2'h0;
                            end else begin
                                sync_ld[i] = 1'b1;
                            end
                        end
                    end
                end
                default: ;
            endcase
        end
        // busy flags only have meaning in asynchronous mode
        if (!n.async) begin
            n.pend = 3'h0;
            n.ecnt = '0;
        end
        for (int i = 0; i < 3; i++) begin
            src[i] = sync_ld[i] ? s.w_data : s.tmp[i];
        end

        // timer core, advancing on the selected timer clock
        com = s.ctl[`ATCB_CTL_COM_HI:`ATCB_CTL_COM_LO];
        adv = tick & (s.ctl[`ATCB_CTL_CS_HI:`ATCB_CTL_CS_LO] != 3'h0);
        suppress = s.pend[`ATCB_IX_CNT] | s.pend[`ATCB_IX_CMP] | s.block; // [R10]
        if (adv) begin
            n.block = 1'b0;
            cm_ev = (s.cnt == s.cmp) & ~suppress; // [R19] [R10]
            if (s.ctl[`ATCB_CTL_PWM] && !s.ctl[`ATCB_CTL_CTC]) begin
                if (!s.down) begin
                    if (s.cnt == `ATCB_MAX) begin
                        n.down = 1'b1;
                        n.cnt = s.cnt - 8'h01;
                    end else begin
                        n.cnt = s.cnt + 8'h01;
                    end
                end else if (s.cnt == `ATCB_BOTTOM) begin
                    n.down = 1'b0;
                    ov_ev = 1'b1; // [R20]
                    n.cnt = s.cnt + 8'h01;
                end else begin
                    n.cnt = s.cnt - 8'h01;
                end
            end else begin
                n.down = 1'b0;
                if (s.ctl[`ATCB_CTL_CTC] && !s.ctl[`ATCB_CTL_PWM] && cm_ev) begin
                    n.cnt = `ATCB_BOTTOM;
                end else if (s.cnt == `ATCB_MAX) begin
                    n.cnt = `ATCB_BOTTOM;
                    ov_ev = 1'b1; // [R20]
                end else begin
                    n.cnt = s.cnt + 8'h01;
                end
            end
        end

        // loads from temporary registers override counting
        if (xfer[`ATCB_IX_CNT] || sync_ld[`ATCB_IX_CNT]) begin
            n.cnt = src[`ATCB_IX_CNT];
            n.block = 1'b1;
        end
        if (xfer[`ATCB_IX_CMP] || sync_ld[`ATCB_IX_CMP]) begin
            n.cmp = src[`ATCB_IX_CMP];
        end
        if (xfer[`ATCB_IX_CTL] || sync_ld[`ATCB_IX_CTL]) begin
            n.ctl = src[`ATCB_IX_CTL];
            n.ctl[`ATCB_CTL_FORCE] = 1'b0;
            force_cmp = src[`ATCB_IX_CTL][`ATCB_CTL_FORCE] &
                        ~src[`ATCB_IX_CTL][`ATCB_CTL_PWM];
        end

        // compare pin follows the timer clock directly
        if (!s.ctl[`ATCB_CTL_PWM]) begin
            if (cm_ev || force_cmp) begin
                unique case (com)
                    2'h0: ;
                    2'h1: n.cmp_out = ~s.cmp_out; // [R16]
                    2'h2: n.cmp_out = 1'b0;
                    2'h3: n.cmp_out = 1'b1;
                endcase
            end
        end else if (com[1]) begin
            if (cm_ev) begin
                n.cmp_out = s.down ? ~com[0] : com[0]; // [R16]
            end
            if (s.ctl[`ATCB_CTL_CTC] && ov_ev) begin
                n.cmp_out = ~com[0];
            end
        end

        if (tick) begin
            n.cnt_sync = n.cnt; // [R14]
        end

        // flags: async events wait one timer cycle plus three cycles here
        evq_c = cm_ev & ~s.wake_blk; // [R11]
        evq_o = ov_ev & ~s.wake_blk;
        n.pipe_c = {s.pipe_c[1:0], evq_c & s.async}; // [R15]
        n.pipe_o = {s.pipe_o[1:0], evq_o & s.async};
        set_c = s.pipe_c[2] | (evq_c & ~s.async);
        set_o = s.pipe_o[2] | (evq_o & ~s.async);
        clr_c = vec_ack_compare |
                (wr_en && s.aw_addr == `ATCB_OFF_FLAGS && s.w_data[`ATCB_BIT_CMP]);
        clr_o = vec_ack_overflow |
                (wr_en && s.aw_addr == `ATCB_OFF_FLAGS && s.w_data[`ATCB_BIT_OVF]);
        // set wins over a clear in the same cycle
        n.flg[`ATCB_BIT_CMP] = set_c | (s.flg[`ATCB_BIT_CMP] & ~clr_c); // [R19]
        n.flg[`ATCB_BIT_OVF] = set_o | (s.flg[`ATCB_BIT_OVF] & ~clr_o); // [R20]
        n.irq_c = s.flg[`ATCB_BIT_CMP] & s.ien[`ATCB_BIT_CMP] & s.gie; // [R17]
        n.irq_o = s.flg[`ATCB_BIT_OVF] & s.ien[`ATCB_BIT_OVF] & s.gie; // [R18]

        // wake-up starts on the timer clock after the condition
        if (saving && s.gie && ((evq_c && s.ien[`ATCB_BIT_CMP]) ||
                                (evq_o && s.ien[`ATCB_BIT_OVF]))) begin
            n.wake_pend = 1'b1;
        end
        if (s.wake_pend && tick) begin
            n.wake_pend = 1'b0;
            n.wake_req = 1'b1; // [R13]
            n.wake_blk = 1'b1; // [R11]
        end else if (s.wake_blk && tick) begin
            n.wake_blk = 1'b0;
        end
        if (sleep_mode == `ATCB_SLP_ACTIVE) begin
            n.wake_req = 1'b0;
        end

        // read channel
        unique case (araddr[7:0])
            `ATCB_OFF_STATUS: begin
                rd[`ATCB_ST_ASYNC] = s.async;
                rd[`ATCB_ST_UB_CNT] = s.pend[`ATCB_IX_CNT];
                rd[`ATCB_ST_UB_CMP] = s.pend[`ATCB_IX_CMP];
                rd[`ATCB_ST_UB_CTL] = s.pend[`ATCB_IX_CTL];
            end
            `ATCB_OFF_MASK: rd[`ATCB_BIT_CMP:`ATCB_BIT_OVF] = s.ien;
            `ATCB_OFF_FLAGS: rd[`ATCB_BIT_CMP:`ATCB_BIT_OVF] = s.flg;
            `ATCB_OFF_CNT: rd = s.cnt_sync; // [R7] [R14]
            `ATCB_OFF_CMP: rd = s.tmp[`ATCB_IX_CMP]; // [R7]
            `ATCB_OFF_CTL: begin
                rd = s.tmp[`ATCB_IX_CTL]; // [R7]
                rd[`ATCB_CTL_FORCE] = 1'b0;
            end
            `ATCB_OFF_CPU: rd[`ATCB_CPU_GIE] = s.gie;
            default: rd = 8'h00;
        endcase
        if (s.arready && arvalid) begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rdata = {24'h000000, rd};
            n.rresp = is_mapped(araddr[7:0]) ? `ATCB_RESP_OKAY : `ATCB_RESP_SLVERR;
        end
        if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end
        n.awready = ~n.aw_got & ~n.bvalid;
        n.wready = ~n.w_got & ~n.bvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign osc_enable = s.osc_run;
    assign wake_req = s.wake_req;
    assign irq_compare = s.irq_c;
    assign irq_overflow = s.irq_o;
    assign compare_out = s.cmp_out;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_cnt_busy_set: assert property (wr_en && s.aw_addr == `ATCB_OFF_CNT && s.async
        |=> s.pend[`ATCB_IX_CNT] && !s.bvalid == 1'b0) // [R3]
        else $error("counter busy not set on async write");
    a_cmp_busy_set: assert property (wr_en && s.aw_addr == `ATCB_OFF_CMP && s.async
        |=> s.pend[`ATCB_IX_CMP]) // [R4]
        else $error("compare busy not set on async write");
    a_ctl_busy_set: assert property (wr_en && s.aw_addr == `ATCB_OFF_CTL && s.async
        |=> s.pend[`ATCB_IX_CTL]) // [R5]
        else $error("control busy not set on async write");
    a_cmp_xfer_load: assert property ($fell(s.pend[`ATCB_IX_CMP]) && s.async
        |-> $past(tick) && s.cmp == $past(s.tmp[`ATCB_IX_CMP])) // [R8]
        else $error("compare not loaded from temporary on busy clear");
    a_cnt_read_hold: assert property (!$past(tick) |-> $stable(s.cnt_sync)) // [R14]
        else $error("counter read register moved without a timer edge");
    a_match_busy_off: assert property (s.pend[`ATCB_IX_CNT] || s.pend[`ATCB_IX_CMP]
        |-> !cm_ev) // [R10]
        else $error("compare match while transfer pending");
    a_flag_sync_lat: assert property (s.async && evq_c
        |-> ##4 s.flg[`ATCB_BIT_CMP]) // [R15]
        else $error("async compare flag not set four cycles after event");
    a_irq_cmp_gate: assert property (s.irq_c |-> $past(s.flg[`ATCB_BIT_CMP]
        && s.ien[`ATCB_BIT_CMP] && s.gie)) // [R17]
        else $error("compare irq without flag, enable and global enable");
    a_irq_ovf_gate: assert property (s.irq_o |-> $past(s.flg[`ATCB_BIT_OVF]
        && s.ien[`ATCB_BIT_OVF] && s.gie)) // [R18]
        else $error("overflow irq without flag, enable and global enable");
    a_flag_one_clear: assert property (clr_c && !set_c
        |=> !s.flg[`ATCB_BIT_CMP]) // [R19]
        else $error("compare flag survived a clear");
    a_osc_pdown_off: assert property (sleep_mode == `ATCB_SLP_PDOWN
        |=> !s.osc_run) // [R12]
        else $error("oscillator running in power-down");

    c_async_xfer: cover property (s.async && xfer[`ATCB_IX_CMP]);
    c_async_flag: cover property (s.async && $rose(s.flg[`ATCB_BIT_CMP]));
    c_overflow: cover property (ov_ev);
    c_wake: cover property ($rose(s.wake_req));

endmodule : atcb_top

// [logic/atcb_defines.svh]
`ifndef ATCB_DEFINES_SVH
`define ATCB_DEFINES_SVH

// register byte offsets
`define ATCB_OFF_STATUS 8'h00
`define ATCB_OFF_MASK 8'h04
`define ATCB_OFF_FLAGS 8'h08
`define ATCB_OFF_CNT 8'h0C
`define ATCB_OFF_CMP 8'h10
`define ATCB_OFF_CTL 8'h14
`define ATCB_OFF_CPU 8'h18

// async_timer_status fields
`define ATCB_ST_ASYNC 3
`define ATCB_ST_UB_CNT 2
`define ATCB_ST_UB_CMP 1
`define ATCB_ST_UB_CTL 0

// mask and flag fields
`define ATCB_BIT_CMP 1
`define ATCB_BIT_OVF 0

// timer_control fields
`define ATCB_CTL_FORCE 7
`define ATCB_CTL_PWM 6
`define ATCB_CTL_COM_HI 5
`define ATCB_CTL_COM_LO 4
`define ATCB_CTL_CTC 3
`define ATCB_CTL_CS_HI 2
`define ATCB_CTL_CS_LO 0

// cpu_status_word global enable
`define ATCB_CPU_GIE 7

// buffered register slots
`define ATCB_IX_CNT 0
`define ATCB_IX_CMP 1
`define ATCB_IX_CTL 2

// sleep mode codes
`define ATCB_SLP_ACTIVE 3'h0
`define ATCB_SLP_PDOWN 3'h2
`define ATCB_SLP_PSAVE 3'h3
`define ATCB_SLP_STANDBY 3'h6
`define ATCB_SLP_EXTSTBY 3'h7

// timing and values
`define ATCB_XFER_LAST 2'h1
`define ATCB_MAX 8'hFF
`define ATCB_BOTTOM 8'h00
`define ATCB_RESP_OKAY 2'h0
`define ATCB_RESP_SLVERR 2'h2

`endif

// [logic/atcb_pkg.sv]
package atcb_pkg;

    typedef struct packed {
        logic async;
        logic gie;
        logic [1:0] ien;
        logic [1:0] flg;
        logic [2:0] pend;
        logic [2:0][1:0] ecnt;
        logic [2:0][7:0] tmp;
        logic [7:0] cnt;
        logic [7:0] cmp;
        logic [7:0] ctl;
        logic [7:0] cnt_sync;
        logic down;
        logic block;
        logic osc_prev;
        logic osc_run;
        logic [2:0] pipe_c;
        logic [2:0] pipe_o;
        logic wake_pend;
        logic wake_req;
        logic wake_blk;
        logic cmp_out;
        logic irq_c;
        logic irq_o;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [7:0] w_data;
        logic w_lane;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } atcb_state_s;

endpackage : atcb_pkg

// [verification/atcb_osc_model.sv]
module atcb_osc_model #(
    parameter int HALF_NS = 520
) (
    // oscillator enable from the bridge
    input wire logic run,
    // crystal pin
    output logic timer_osc_in
);
    timeunit 1ns;
    timeprecision 1ns;

    initial timer_osc_in = 1'h0;

    // phase unrelated to aclk; stops while the bridge gates it off
    always #(HALF_NS) begin
        if (run) begin
            timer_osc_in = ~timer_osc_in;
        end
    end
endmodule : atcb_osc_model

// [verification/test_async_timer0_clock_bridge.sv]
`include "atcb_defines.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module test_async_timer0_clock_bridge;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {logic [1:0] resp; logic [7:0] data; logic [7:0] msk;} atcb_note_s;

    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic [2:0] sleep_mode = 3'h0;
    logic vec_ack_compare = 1'h0, vec_ack_overflow = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, osc_enable, wake_req;
    logic irq_compare, irq_overflow, compare_out, timer_osc_in;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] watch;
    int mismatches = 0, compares = 0, cycles = 0, seed = 52524;
    atcb_note_s notes[$];

    always #25 aclk = ~aclk;

    atcb_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .timer_osc_in(timer_osc_in), .sleep_mode(sleep_mode), .osc_enable(osc_enable),
        .wake_req(wake_req), .vec_ack_compare(vec_ack_compare),
        .vec_ack_overflow(vec_ack_overflow), .irq_compare(irq_compare),
        .irq_overflow(irq_overflow), .compare_out(compare_out));

    atcb_osc_model u_osc (.run(osc_enable), .timer_osc_in(timer_osc_in));

    // level outputs that the scenarios wait on, picked by index
    assign watch = {wake_req, irq_overflow, irq_compare};

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            print_verdict();
        end
    end

    // response checker: oldest note against each completed response
    always @(posedge aclk) begin
        atcb_note_s n;
        if ((bvalid && bready) || (rvalid && rready)) begin
            n = notes.pop_front();
            `CHK(bvalid ? bresp : rresp, n.resp)
            if (rvalid) begin
                `CHK(rdata & {24'hFFFFFF, n.msk}, {24'h0, n.data & n.msk})
            end
        end
    end

    function automatic logic [1:0] resp_of(input logic [7:0] a);
        return (a > `ATCB_OFF_CPU) ? `ATCB_RESP_SLVERR : `ATCB_RESP_OKAY;
    endfunction : resp_of

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        atcb_note_s n;
        logic aw_ok;
        logic w_ok;
        @(posedge aclk);
        n = '{resp_of(a), 8'h00, 8'h00};
        notes.push_back(n);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awready && !aw_ok) begin
                aw_ok = 1'h1;
                awvalid <= 1'h0;
            end
            if (wready && !w_ok) begin
                w_ok = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'h1);
        bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
        output logic [7:0] d);
        atcb_note_s n;
        @(posedge aclk);
        n = '{resp_of(a), e, m};
        notes.push_back(n);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        d = rdata[7:0];
        rready <= 1'h0;
    endtask : rd

    // never rewrite a buffered register while its transfer is pending
    task automatic wait_idle();
        logic [7:0] s;
        s = 8'hFF;
        while ((s & 8'h07) !== 8'h00) begin
            rd(`ATCB_OFF_STATUS, 8'h00, 8'h00, s);
        end
    endtask : wait_idle

    task automatic wait_high(input int sel, input int lim);
        int k;
        k = 0;
        while (watch[sel] !== 1'h1 && k < lim) begin
            @(posedge aclk);
            k++;
        end
    endtask : wait_high

    initial begin
        logic [7:0] v;
        logic [7:0] c;
        logic [7:0] s;
        logic [2:0] m;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            rd(8'(4 * i), 8'h00, 8'hFF, s);
        end
        rd(8'h1C, 8'h00, 8'hFF, s);
        wr(8'h20, 8'h55);
        v = 8'($random(seed));
        wr(`ATCB_OFF_CNT, v);
        rd(`ATCB_OFF_CNT, v, 8'hFF, s);
        // switch to the oscillator with interrupts off
        wr(`ATCB_OFF_STATUS, 8'h08);
        rd(`ATCB_OFF_STATUS, 8'h08, 8'hFF, s);
        for (int i = 0; i < 3; i++) begin
            v = 8'($random(seed)) & ((i == 2) ? 8'h78 : 8'hFF);
            wr(`ATCB_OFF_CNT + 8'(4 * i), v);
            rd(`ATCB_OFF_STATUS, 8'h08 | (8'h04 >> i), 8'hFF, s);
            rd(`ATCB_OFF_CNT + 8'(4 * i), v, (i == 0) ? 8'h00 : 8'hFF, s);
            wait_idle();
            // counter view refreshes only on oscillator edges
            repeat (60) @(posedge aclk);
            rd(`ATCB_OFF_CNT + 8'(4 * i), v, 8'hFF, s);
        end
        v = 8'($random(seed));
        c = 8'($random(seed));
        wr(`ATCB_OFF_CNT, v);
        wr(`ATCB_OFF_CMP, c);
        rd(`ATCB_OFF_STATUS, 8'h0E, 8'hFF, s);
        wait_idle();
        repeat (60) @(posedge aclk);
        rd(`ATCB_OFF_CNT, v, 8'hFF, s);
        rd(`ATCB_OFF_CMP, c, 8'hFF, s);
        wr(`ATCB_OFF_CNT, 8'h00);
        wr(`ATCB_OFF_CMP, 8'h05);
        wait_idle();
        wr(`ATCB_OFF_FLAGS, 8'h03);
        wr(`ATCB_OFF_CPU, 8'h80);
        wr(`ATCB_OFF_MASK, 8'h02);
        rd(`ATCB_OFF_MASK, 8'h02, 8'hFF, s);
        // count every oscillator rising edge, compare pin set on match
        wr(`ATCB_OFF_CTL, 8'h31);
        `CHK(compare_out, 1'h0)
        wait_high(0, 1000);
        `CHK(irq_compare, 1'h1)
        `CHK(compare_out, 1'h1)
        `CHK(irq_overflow, 1'h0)
        rd(`ATCB_OFF_FLAGS, 8'h02, 8'hFF, s);
        vec_ack_compare <= 1'h1;
        @(posedge aclk);
        vec_ack_compare <= 1'h0;
        rd(`ATCB_OFF_FLAGS, 8'h00, 8'h02, s);
        `CHK(irq_compare, 1'h0)
        wr(`ATCB_OFF_MASK, 8'h01);
        wait_high(1, 8000);
        `CHK(irq_overflow, 1'h1)
        wr(`ATCB_OFF_CPU, 8'h00);
        repeat (2) @(posedge aclk);
        `CHK(irq_overflow, 1'h0)
        wr(`ATCB_OFF_FLAGS, 8'h01);
        rd(`ATCB_OFF_FLAGS, 8'h00, 8'h01, s);
        for (int i = 0; i < 5; i++) begin
            m = (i == 0) ? `ATCB_SLP_ACTIVE : (i == 1) ? `ATCB_SLP_PDOWN : `ATCB_SLP_PSAVE;
            m = (i == 3) ? `ATCB_SLP_STANDBY : (i == 4) ? `ATCB_SLP_EXTSTBY : m;
            sleep_mode <= m;
            repeat (3) @(posedge aclk);
            `CHK(osc_enable, 1'(m != `ATCB_SLP_PDOWN && m != `ATCB_SLP_STANDBY))
        end
        sleep_mode <= `ATCB_SLP_PSAVE;
        wr(`ATCB_OFF_MASK, 8'h02);
        // no wake-up without the global enable
        wr(`ATCB_OFF_CPU, 8'h80);
        wait_high(2, 8000);
        `CHK(wake_req, 1'h1)
        sleep_mode <= `ATCB_SLP_ACTIVE;
        repeat (3) @(posedge aclk);
        `CHK(wake_req, 1'h0)
        print_verdict();
    end
endmodule : test_async_timer0_clock_bridge
